// File: hdl/ihq_host_intr.sv
`timescale 1ns/1ps
`include "ihq_regs.svh"

// Summary of operation
// - both data words read receive, write transmit
// - byte, word, dword accesses mix freely
// - 16-bit bus two buffers, 32-bit one
// - data words consecutive on 16, one on 32
// - enable 15 gates link change, resets 0
// - enable 14 gates transmit done, resets 0
// - enable 13 gates receive ready, resets 0
// - enable 11 gates receive overrun, resets 0
// - enables 9, 8 gate process stopped
// - enable 7 gates error frame, resets 0
// - interrupt when any enabled status set
// - reads keep status; write one clears
// - status 15 set on any link change
// - status 14 set when transmit done
// - status 13 set when frame received
// - status 11 set on receive overrun
// - status 9, 8 on stop; reset one
// - status 7 set on error frame
// - status set by edge, held until cleared
module ihq_host_intr
  import ihq_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic host_bus32_i,
  input ihq_host_req_t host_req_i,
  output logic host_ack_o,
  output logic [DATA_W-1:0] host_rdata_o,
  input ihq_events_t events_i,
  output logic rx_pop_o,
  output logic [3:0] rx_be_o,
  input wire logic [DATA_W-1:0] rx_data_i,
  output logic tx_push_o,
  output ihq_tx_word_t tx_word_o,
  output logic irq_n_o
);

  // mode strap and its two-stage synchroniser
  logic bus32_meta_reg;
  logic bus32_sync_reg;
  logic bus32_reg;

  // host port bookkeeping
  ihq_port_state_t port_reg;
  ihq_port_state_t port_next;
  logic host_addr1_reg;
  ihq_dword_t acc;

  // register storage
  logic [15:0] enable_reg;
  logic [15:0] status;
  logic [15:0] status_clear;
  logic [`IHQ_NUM_EVENTS-1:0] evt_vec;
  logic [`IHQ_NUM_EVENTS-1:0] clr_vec;
  logic [`IHQ_NUM_EVENTS-1:0] flag_vec;

  // decode results
  logic hit_intr;
  logic hit_data;
  logic rd_any;
  logic wr_any;
  logic [31:0] read_dword;
  logic irq_next;

  // bit positions of the event sources, highest first
  localparam int EVT_POS [`IHQ_NUM_EVENTS] = '{
    `IHQ_BIT_LINK,
    `IHQ_BIT_TX_DONE,
    `IHQ_BIT_RX_READY,
    `IHQ_BIT_RX_OVERRUN,
    `IHQ_BIT_TX_STOP,
    `IHQ_BIT_RX_STOP,
    `IHQ_BIT_RX_ERROR
  };

  // reset value of each source flag
  localparam logic [15:0] STATUS_RST = `IHQ_STATUS_RESET;

  // true when the access falls in the given bank and doubleword
  function automatic logic hits(
    input logic [4:0] bank,
    input logic [1:0] dword,
    input logic [4:0] want_bank,
    input logic [3:0] want_ofs
  );
    hits = (bank == want_bank) && (dword == want_ofs[3:2]);
  endfunction : hits

  // merge write data into a 16-bit register under two byte enables
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be
  );
    merge16 = {be[1] ? new_val[15:8] : old_val[15:8],
               be[0] ? new_val[7:0] : old_val[7:0]};
  endfunction : merge16

  // the bus width strap passes three flops before use
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      bus32_meta_reg <= 1'b0;
      bus32_sync_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      bus32_meta_reg <= host_bus32_i;
      bus32_sync_reg <= bus32_meta_reg;
    end
  end

  // the synchronised width selects the data port layout
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      bus32_reg <= 1'b0;
    else if (ce_i)
      bus32_reg <= bus32_sync_reg;
  end

  // fold the host access onto a doubleword with lane enables
  ihq_lane_map u_lane_map (
    .bus32_i(bus32_reg),
    .addr_i(host_req_i.addr),
    .be_i(host_req_i.be),
    .wdata_i(host_req_i.wdata),
    .dword_o(acc)
  );

  // address decode; low and high data words share one doubleword
  assign hit_intr = hits(host_req_i.bank, acc.dword,
                         `IHQ_BANK_INTR, `IHQ_OFS_ENABLE);
  assign hit_data = hits(host_req_i.bank, acc.dword,
                         `IHQ_BANK_QUEUE, `IHQ_OFS_DATA_HIGH);
  assign rd_any = host_req_i.rd & ~host_req_i.wr;
  assign wr_any = host_req_i.wr & ~host_req_i.rd;

  // one reply cycle follows every access that asserts only one of rd and wr
  always_comb
  begin
    port_next = IHQ_IDLE;
    unique case (port_reg)
      IHQ_IDLE:
        if (rd_any || wr_any)
          port_next = IHQ_REPLY;
      IHQ_REPLY:
        if (rd_any || wr_any)
          port_next = IHQ_REPLY;
    endcase
  end

  // port state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      port_reg <= IHQ_IDLE;
    else if (ce_i)
      port_reg <= port_next;
  end

  assign host_ack_o = (port_reg == IHQ_REPLY);

  // enable register, only implemented bits are writable
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      enable_reg <= `IHQ_ENABLE_RESET;
    else if (ce_i && wr_any && hit_intr)
      enable_reg <= merge16(enable_reg, acc.data[15:0], acc.be[1:0])
                    & `IHQ_IMPL_MASK;
  end

  // write one to a status bit clears it; reads leave it alone
  always_comb
  begin
    status_clear = 16'h0000;
    if (wr_any && hit_intr)
      status_clear = merge16(16'h0000, acc.data[31:16], acc.be[3:2]);
  end

  // gather the event levels in bit-position order
  assign evt_vec = {events_i.link_up,
                    events_i.tx_done,
                    events_i.rx_ready,
                    events_i.rx_overrun,
                    events_i.tx_stopped,
                    events_i.rx_stopped,
                    events_i.rx_error_frame};

  // one sticky flag per event source
  genvar gi;
  generate
    for (gi = 0; gi < `IHQ_NUM_EVENTS; gi++)
    begin : g_flag
      assign clr_vec[gi] = status_clear[EVT_POS[gi]];
      ihq_sticky_bit #(
        .RESET_VALUE(STATUS_RST[EVT_POS[gi]]),
        .BOTH_EDGES(EVT_POS[gi] == `IHQ_BIT_LINK)
      ) u_flag (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .event_i(evt_vec[`IHQ_NUM_EVENTS-1-gi]),
        .clear_i(clr_vec[gi]),
        .flag_o(flag_vec[gi])
      );
    end
  endgenerate

  // place the flags at their positions, reserved bits read zero
  always_comb
  begin
    status = 16'h0000;
    for (int i = 0; i < `IHQ_NUM_EVENTS; i++)
      status[EVT_POS[i]] = flag_vec[i];
  end

  // assemble the addressed doubleword for a read
  always_comb
  begin
    read_dword = 32'h0000_0000;
    if (hit_intr)
      read_dword = {status, enable_reg};
    else if (hit_data)
      read_dword = rx_data_i;
  end

  // reads of the data port pull from the receive queue
  assign rx_pop_o = ce_i & rd_any & hit_data;
  assign rx_be_o = acc.be;

  // read data is registered, narrowed for a 16-bit bus
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      host_rdata_o <= '0;
      host_addr1_reg <= 1'b0;
    end
    else if (ce_i && rd_any)
    begin
      host_addr1_reg <= host_req_i.addr[1];
      if (bus32_reg)
        host_rdata_o <= read_dword;
      else if (host_req_i.addr[1])
        host_rdata_o <= {16'h0000, read_dword[31:16]};
      else
        host_rdata_o <= {16'h0000, read_dword[15:0]};
    end
  end

  // writes of the data port push into the transmit queue
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_push_o <= 1'b0;
      tx_word_o <= '0;
    end
    else if (ce_i)
    begin
      tx_push_o <= wr_any & hit_data & (|acc.be);
      if (wr_any && hit_data)
      begin
        tx_word_o.be <= acc.be;
        tx_word_o.data <= acc.data;
      end
    end
  end

  // any enabled pending status drives the interrupt pin low
  assign irq_next = |(status & enable_reg);

  // interrupt pin register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_n_o <= 1'b1;
    else if (ce_i)
      irq_n_o <= ~irq_next;
  end

endmodule : ihq_host_intr

// File: hdl/ihq_regs.svh
`ifndef IHQ_REGS_SVH
`define IHQ_REGS_SVH

// register banks selected by the host bank input
`define IHQ_BANK_QUEUE 5'h11
`define IHQ_BANK_INTR 5'h12

// byte offsets inside a bank
`define IHQ_OFS_ENABLE 4'h0
`define IHQ_OFS_STATUS 4'h2
`define IHQ_OFS_DATA_LOW 4'h8
`define IHQ_OFS_DATA_HIGH 4'hA

// bit positions shared by the enable and the status register
`define IHQ_BIT_LINK 15
`define IHQ_BIT_TX_DONE 14
`define IHQ_BIT_RX_READY 13
`define IHQ_BIT_RX_OVERRUN 11
`define IHQ_BIT_TX_STOP 9
`define IHQ_BIT_RX_STOP 8
`define IHQ_BIT_RX_ERROR 7

// implemented bits and reset values
`define IHQ_IMPL_MASK 16'hEB80
`define IHQ_ENABLE_RESET 16'h0000
`define IHQ_STATUS_RESET 16'h0300

// number of event sources
`define IHQ_NUM_EVENTS 7

`endif

// File: hdl/ihq_pkg.sv
package ihq_pkg;

  // one host access as seen on the parallel bus
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] bank;
    logic [3:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ihq_host_req_t;

  // host access folded onto a doubleword view
  typedef struct packed {
    logic [1:0] dword;
    logic [3:0] be;
    logic [31:0] data;
  } ihq_dword_t;

  // level inputs from the queue engines and the link
  typedef struct packed {
    logic link_up;
    logic tx_done;
    logic rx_ready;
    logic rx_overrun;
    logic tx_stopped;
    logic rx_stopped;
    logic rx_error_frame;
  } ihq_events_t;

  // word handed to the transmit queue
  typedef struct packed {
    logic [3:0] be;
    logic [31:0] data;
  } ihq_tx_word_t;

  // reply state of the host port
  typedef enum logic [1:0] {
    IHQ_IDLE,
    IHQ_REPLY
  } ihq_port_state_t;

endpackage : ihq_pkg

// File: hdl/ihq_sticky_bit.sv
`timescale 1ns/1ps

// one edge-set, write-one-clear status flag
module ihq_sticky_bit
  import ihq_pkg::*;
#(
  parameter bit RESET_VALUE = 1'b0,
  parameter bit BOTH_EDGES = 1'b0
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic event_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic prev_reg;
  logic edge_seen;

  // previous level of the event for edge detection
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      prev_reg <= 1'b0;
    else if (ce_i)
      prev_reg <= event_i;
  end

  // rising edge, or any edge for the link source
  assign edge_seen = BOTH_EDGES ? (event_i ^ prev_reg)
                                : (event_i & ~prev_reg);

  // flag holds until written with one; a new edge wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      flag_o <= RESET_VALUE;
    else if (ce_i)
    begin
      if (edge_seen)
        flag_o <= 1'b1;
      else if (clear_i)
        flag_o <= 1'b0;
    end
  end

endmodule : ihq_sticky_bit

// File: hdl/ihq_lane_map.sv
`timescale 1ns/1ps

// folds a 16- or 32-bit host access onto a doubleword view
module ihq_lane_map
  import ihq_pkg::*;
(
  input wire logic bus32_i,
  input wire logic [3:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output ihq_dword_t dword_o
);

  // a 16-bit access lands in the half chosen by address bit 1
  always_comb
  begin
    dword_o.dword = addr_i[3:2];
    if (bus32_i)
    begin
      dword_o.be = be_i;
      dword_o.data = wdata_i;
    end
    else if (addr_i[1])
    begin
      dword_o.be = {be_i[1:0], 2'b00};
      dword_o.data = {wdata_i[15:0], 16'h0000};
    end
    else
    begin
      dword_o.be = {2'b00, be_i[1:0]};
      dword_o.data = {16'h0000, wdata_i[15:0]};
    end
  end

endmodule : ihq_lane_map

// File: verification/ihq_host_intr_props.sv
`timescale 1ns/1ps

// port-level checks of the host interrupt and queue data block
module ihq_host_intr_props
  import ihq_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input ihq_host_req_t host_req_i,
  input wire logic host_ack_o,
  input wire logic [DATA_W-1:0] host_rdata_o,
  input ihq_events_t events_i,
  input wire logic rx_pop_o,
  input wire logic [3:0] rx_be_o,
  input wire logic [DATA_W-1:0] rx_data_i,
  input wire logic tx_push_o,
  input ihq_tx_word_t tx_word_o,
  input wire logic irq_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // an accepted access, then accesses aimed at the data port
  sequence s_take;
    ce_i && (host_req_i.rd ^ host_req_i.wr);
  endsequence
  sequence s_data;
    s_take ##0 host_req_i.bank == 5'h11 && host_req_i.addr == 4'hA &&
      host_req_i.be[1:0] != 2'h0;
  endsequence
  property p_ack;
    s_take |=> host_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_push;
    s_data ##0 host_req_i.wr |=> tx_push_o;
  endproperty
  a_push: assert property (p_push) else $error("no transmit push");
  property p_push_src;
    tx_push_o |-> $past(host_req_i.wr) && $past(host_req_i.bank) == 5'h11
      && tx_word_o.be != 4'h0;
  endproperty
  a_push_src: assert property (p_push_src) else $error("stray push");
  property p_pop;
    s_data ##0 host_req_i.rd |-> rx_pop_o && rx_be_o != 4'h0;
  endproperty
  a_pop: assert property (p_pop) else $error("no receive pop");
  property p_pop_data;
    rx_pop_o && rx_be_o == 4'hF |=> host_rdata_o == $past(rx_data_i);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("bad dword");
  property p_rdata_hold;
    !host_req_i.rd || !ce_i |=> $stable(host_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_irq_rise;
    $rose(irq_n_o) |-> $past(host_req_i.wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq dropped");
  property p_irq_fall;
    $fell(irq_n_o) |-> $past(host_req_i.wr, 2) ||
      $past(events_i, 2) != $past(events_i, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq no cause");
endmodule : ihq_host_intr_props

// File: verification/ihq_rx_queue_model.sv
`timescale 1ns/1ps

// receive queue stand-in, data valid only during a pop
module ihq_rx_queue_model
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pop_i,
  output logic [31:0] data_o
);
  logic [15:0] cnt_reg;
  // advance on every pop
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cnt_reg <= 16'h0000;
    else if (pop_i)
      cnt_reg <= cnt_reg + 16'h0001;
  end
  // inverted word outside a pop so stale data never matches
  assign data_o = pop_i ? {16'hC3A5, cnt_reg} : ~{16'hC3A5, cnt_reg};
endmodule : ihq_rx_queue_model

// File: verification/tb_ihq_host_intr.sv
`timescale 1ns/1ps

module tb_ihq_host_intr;
  import ihq_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic bus32 = 1'b0;
  ihq_host_req_t req = '0;
  ihq_events_t ev = '0;
  logic ack, pop, push, irq_n;
  logic [31:0] rdata, rxd, rd_q, m;
  logic [3:0] rx_be, be_q;
  ihq_tx_word_t tw, tw_q;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int bits[7] = '{15, 14, 13, 11, 9, 8, 7};

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  ihq_host_intr ihq_host_intr_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .host_bus32_i(bus32), .host_req_i(req),
    .host_ack_o(ack), .host_rdata_o(rdata), .events_i(ev),
    .rx_pop_o(pop), .rx_be_o(rx_be), .rx_data_i(rxd), .tx_push_o(push),
    .tx_word_o(tw), .irq_n_o(irq_n));

  ihq_rx_queue_model ihq_rx_queue_model_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .pop_i(pop), .data_o(rxd));

  task results;
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // one host access, answer taken one cycle after it is accepted
  task acc(input logic r, w, input logic [4:0] b, input logic [3:0] a, e,
           input logic [31:0] d);
    @(posedge clk_i);
    req <= '{r, w, b, a, e, d};
    @(negedge clk_i);
    be_q = pop ? rx_be : 4'h0;
    @(posedge clk_i);
    req <= '0;
    @(negedge clk_i);
    chk("ack", {31'h0, r ^ w}, {31'h0, ack});
    rd_q = rdata;
    tw_q = push ? tw : '0;
  endtask : acc

  // hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      results;
    end
  end

  // main sequence, 16-bit bus first
  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    acc(1, 0, 5'h11, 4'h2, 4'h3, 0);
    acc(1, 0, 5'h12, 4'h0, 4'h3, 0);
    chk("enable", 0, rd_q);
    acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
    chk("status", 32'h0000_0300, rd_q);
    acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
    chk("status", 32'h0000_0300, rd_q);
    acc(0, 1, 5'h12, 4'h2, 4'h3, 32'h0000_0300);
    acc(0, 1, 5'h12, 4'h0, 4'h3, 32'h0000_FFFF);
    acc(1, 0, 5'h12, 4'h0, 4'h3, 0);
    chk("enable", 32'h0000_EB80, rd_q);
    acc(0, 1, 5'h12, 4'h0, 4'h3, 0);
    foreach (bits[i])
    begin
      m = 32'h0000_0001 << bits[i];
      @(posedge clk_i);
      ev[6 - i] <= 1'b1;
      acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
      chk("status", m, rd_q);
      chk("irq_n", 1, irq_n);
      acc(0, 1, 5'h12, 4'h0, 4'h3, m);
      acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
      chk("irq_n", 0, irq_n);
      acc(0, 1, 5'h12, 4'h2, 4'h3, m);
      acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
      chk("status", 0, rd_q);
      chk("irq_n", 1, irq_n);
      @(posedge clk_i);
      ev[6 - i] <= 1'b0;
      acc(1, 0, 5'h12, 4'h2, 4'h3, 0);
      chk("status", i == 0 ? m : 0, rd_q);
      acc(0, 1, 5'h12, 4'h2, 4'h3, m);
      acc(0, 1, 5'h12, 4'h0, 4'h3, 0);
    end
    acc(0, 1, 5'h11, 4'hA, 4'h3, 32'h0000_1234);
    chk("tx_hi", 32'h000C_1234, {12'h0, tw_q.be, tw_q.data[31:16]});
    acc(0, 1, 5'h11, 4'h8, 4'h2, 32'h0000_5600);
    chk("tx_lo", 32'h0000_0256, {20'h0, tw_q.be, tw_q.data[15:8]});
    acc(0, 1, 5'h11, 4'h0, 4'h3, 32'h0000_1111);
    chk("tx_none", 0, {28'h0, tw_q.be});
    acc(1, 0, 5'h11, 4'hA, 4'h3, 0);
    chk("rx_hi", 32'h0000_C3A5, rd_q);
    chk("rx_be", 32'h0000_000C, {28'h0, be_q});
    acc(1, 0, 5'h11, 4'h8, 4'h3, 0);
    chk("rx_lo", 32'h0000_0001, rd_q);
    acc(1, 1, 5'h12, 4'h2, 4'h3, 0);
    acc(1, 0, 5'h12, 4'hE, 4'h3, 0);
    chk("unmapped", 0, rd_q);
    @(posedge clk_i);
    bus32 <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc(1, 0, 5'h11, 4'h8, 4'hF, 0);
    chk("rx_dw", 32'hC3A5_0002, rd_q);
    chk("rx_be", 32'h0000_000F, {28'h0, be_q});
    acc(0, 1, 5'h11, 4'h8, 4'hF, 32'hDEAD_BEEF);
    chk("tx_dw", 32'hDEAD_BEEF, tw_q.data);
    chk("tx_be", 32'h0000_000F, {28'h0, tw_q.be});
    acc(0, 1, 5'h12, 4'h0, 4'hF, 32'hFFFF_0080);
    acc(1, 0, 5'h12, 4'h0, 4'hF, 0);
    chk("intr_dw", 32'h0000_0080, rd_q);
    results;
  end
endmodule : tb_ihq_host_intr

bind ihq_host_intr ihq_host_intr_props #(.DATA_W(DATA_W)) ihq_host_intr_props_i
  (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
   .host_req_i(host_req_i), .host_ack_o(host_ack_o),
   .host_rdata_o(host_rdata_o), .events_i(events_i), .rx_pop_o(rx_pop_o),
   .rx_be_o(rx_be_o), .rx_data_i(rx_data_i), .tx_push_o(tx_push_o),
   .tx_word_o(tx_word_o), .irq_n_o(irq_n_o));
